//--- rtl/csmp_requester.sv
`timescale 1ns/1ps
// Functional notes
// [R1] Requester sends dword address, byte address divided by four.
// [R2] Read drives 10-bit address and 8-bit function.
// [R3] Read data valid only with completion strobe.
// [R4] Write presents address, function, data, byte mask.
// [R5] Completion strobe marks write done, possibly later.
// [R6] Requester holds all request fields until completion.
// [R7] Write request drops cycle after completion.
// [R8] Root-port override writes read-only fields.
// [R9] Root port configures its space through this port.
// [R10] Loopback capability starts at byte 0x330.
// [R11] Loopback start: write 1 to dword 0xCE.
// [R12] Then retrain: write 0x20 to dword 0x20.
// [R13] Read request held until completion, then dropped.
// [R14] One strobe per request; wait for release.
module csmp_requester (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  csmp_if.req port
);

  // ---------------------------------------------------------------------------
  // Sequencer states and software-visible registers.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, ISSUE, RELEASE} csmp_req_e;

  csmp_req_e state_r, state_nxt;
  csmp_pkg::csmp_lb_e lbStep_r, lbStep_nxt;
  logic writeMode_r, writeMode_nxt;
  logic debug_r, debug_nxt;
  logic [11:0] byteAddr_r, byteAddr_nxt;
  logic [7:0] func_r, func_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] ben_r, ben_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic doneFlag_r, doneFlag_nxt;

  // ---------------------------------------------------------------------------
  // Registered request outputs toward the configuration port.
  // ---------------------------------------------------------------------------
  logic [9:0] ifAddr_r, ifAddr_nxt;
  logic [7:0] ifFunc_r, ifFunc_nxt;
  logic [31:0] ifWdata_r, ifWdata_nxt;
  logic [3:0] ifBen_r, ifBen_nxt;
  logic ifWrite_r, ifWrite_nxt;
  logic ifRead_r, ifRead_nxt;
  logic ifDebug_r, ifDebug_nxt;

  logic access;
  logic wrAccess;
  logic mapped;
  logic busy;

  // ---------------------------------------------------------------------------
  // APB slave decode.
  // ---------------------------------------------------------------------------

  // The slave answers in the first access cycle unless the clock is disabled.
  assign pready = ce;
  assign access = psel & penable & ce;
  assign wrAccess = access & pwrite;
  assign busy = (state_r != IDLE);

  // Flag whether the offset names one of our registers.
  always_comb
  begin
    unique case (paddr)
      csmp_pkg::REG_CTRL,
      csmp_pkg::REG_ADDR,
      csmp_pkg::REG_FUNC,
      csmp_pkg::REG_WDATA,
      csmp_pkg::REG_BEN,
      csmp_pkg::REG_STAT,
      csmp_pkg::REG_RDATA: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped offsets give an error response and read as zero.
  assign pslverr = psel & penable & ~mapped;

  // Read data multiplexer over the stored registers.
  always_comb
  begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      csmp_pkg::REG_CTRL:
      begin
        prdata[csmp_pkg::CTRL_WRITE] = writeMode_r;
        prdata[csmp_pkg::CTRL_DEBUG] = debug_r;
      end
      csmp_pkg::REG_ADDR: prdata[11:0] = byteAddr_r;
      csmp_pkg::REG_FUNC: prdata[7:0] = func_r;
      csmp_pkg::REG_WDATA: prdata = wdata_r;
      csmp_pkg::REG_BEN: prdata[3:0] = ben_r;
      csmp_pkg::REG_STAT:
      begin
        prdata[csmp_pkg::STAT_BUSY] = busy;
        prdata[csmp_pkg::STAT_DONE] = doneFlag_r;
      end
      csmp_pkg::REG_RDATA: prdata = rdata_r;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // Setup registers and request sequencer.
  // ---------------------------------------------------------------------------

  // Setup registers take writes at any time; a start while busy is ignored.
  always_comb
  begin
    state_nxt = state_r;
    lbStep_nxt = lbStep_r;
    writeMode_nxt = writeMode_r;
    debug_nxt = debug_r;
    byteAddr_nxt = byteAddr_r;
    func_nxt = func_r;
    wdata_nxt = wdata_r;
    ben_nxt = ben_r;
    rdata_nxt = rdata_r;
    doneFlag_nxt = doneFlag_r;
    ifAddr_nxt = ifAddr_r;
    ifFunc_nxt = ifFunc_r;
    ifWdata_nxt = ifWdata_r;
    ifBen_nxt = ifBen_r;
    ifWrite_nxt = ifWrite_r;
    ifRead_nxt = ifRead_r;
    ifDebug_nxt = ifDebug_r;
    if (wrAccess)
    begin
      unique case (paddr)
        csmp_pkg::REG_CTRL:
        begin
          writeMode_nxt = pwdata[csmp_pkg::CTRL_WRITE];
          debug_nxt = pwdata[csmp_pkg::CTRL_DEBUG];
        end
        csmp_pkg::REG_ADDR: byteAddr_nxt = pwdata[11:0];
        csmp_pkg::REG_FUNC: func_nxt = pwdata[7:0];
        csmp_pkg::REG_WDATA: wdata_nxt = pwdata;
        csmp_pkg::REG_BEN: ben_nxt = pwdata[3:0];
        csmp_pkg::REG_STAT:
        begin
          if (pwdata[csmp_pkg::STAT_DONE])
          begin
            doneFlag_nxt = 1'b0;
          end
        end
        default: doneFlag_nxt = doneFlag_r;
      endcase
    end
    unique case (state_r)
      IDLE:
      begin
        if (wrAccess && paddr == csmp_pkg::REG_CTRL && pwdata[csmp_pkg::CTRL_LOOPBACK])
        begin
          ifAddr_nxt = csmp_pkg::DW_LB_CTRL; // [R11]
          ifFunc_nxt = func_r;
          ifWdata_nxt = csmp_pkg::LB_START_DATA; // [R11]
          ifBen_nxt = csmp_pkg::LB_START_BE;
          ifWrite_nxt = 1'b1;
          ifRead_nxt = 1'b0;
          ifDebug_nxt = 1'b0;
          lbStep_nxt = csmp_pkg::LB_START;
          state_nxt = ISSUE;
        end
        else if (wrAccess && paddr == csmp_pkg::REG_CTRL && pwdata[csmp_pkg::CTRL_GO])
        begin
          ifAddr_nxt = byteAddr_r[11:2]; // [R1] [R9]
          ifFunc_nxt = func_r; // [R2]
          ifWdata_nxt = wdata_r; // [R4]
          ifBen_nxt = ben_r; // [R4]
          ifWrite_nxt = pwdata[csmp_pkg::CTRL_WRITE]; // [R4]
          ifRead_nxt = ~pwdata[csmp_pkg::CTRL_WRITE]; // [R13]
          ifDebug_nxt = pwdata[csmp_pkg::CTRL_DEBUG] & pwdata[csmp_pkg::CTRL_WRITE]; // [R8]
          lbStep_nxt = csmp_pkg::LB_NONE;
          state_nxt = ISSUE;
        end
      end
      ISSUE:
      begin
        // Every request field stays put until the strobe is seen.
        if (port.done) // [R6]
        begin
          ifWrite_nxt = 1'b0; // [R7]
          ifRead_nxt = 1'b0; // [R13]
          ifDebug_nxt = 1'b0;
          if (ifRead_r)
          begin
            rdata_nxt = port.readData; // [R3]
          end
          state_nxt = RELEASE;
        end
      end
      RELEASE:
      begin
        // One idle cycle lets the device see the request dropped.
        if (lbStep_r == csmp_pkg::LB_START)
        begin
          ifAddr_nxt = csmp_pkg::DW_LINK_CTRL; // [R12]
          ifWdata_nxt = csmp_pkg::RETRAIN_DATA; // [R12]
          ifBen_nxt = csmp_pkg::RETRAIN_BE; // [R12]
          ifWrite_nxt = 1'b1;
          lbStep_nxt = csmp_pkg::LB_RETRAIN;
          state_nxt = ISSUE;
        end
        else
        begin
          doneFlag_nxt = 1'b1;
          lbStep_nxt = csmp_pkg::LB_NONE;
          state_nxt = IDLE;
        end
      end
    endcase
  end

  // Register all requester state; the clock enable freezes it.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= IDLE;
      lbStep_r <= csmp_pkg::LB_NONE;
      writeMode_r <= 1'b0;
      debug_r <= 1'b0;
      byteAddr_r <= 12'h000;
      func_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      ben_r <= 4'h0;
      rdata_r <= 32'h0000_0000;
      doneFlag_r <= 1'b0;
      ifAddr_r <= 10'h000;
      ifFunc_r <= 8'h00;
      ifWdata_r <= 32'h0000_0000;
      ifBen_r <= 4'h0;
      ifWrite_r <= 1'b0;
      ifRead_r <= 1'b0;
      ifDebug_r <= 1'b0;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      lbStep_r <= lbStep_nxt;
      writeMode_r <= writeMode_nxt;
      debug_r <= debug_nxt;
      byteAddr_r <= byteAddr_nxt;
      func_r <= func_nxt;
      wdata_r <= wdata_nxt;
      ben_r <= ben_nxt;
      rdata_r <= rdata_nxt;
      doneFlag_r <= doneFlag_nxt;
      ifAddr_r <= ifAddr_nxt;
      ifFunc_r <= ifFunc_nxt;
      ifWdata_r <= ifWdata_nxt;
      ifBen_r <= ifBen_nxt;
      ifWrite_r <= ifWrite_nxt;
      ifRead_r <= ifRead_nxt;
      ifDebug_r <= ifDebug_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Drive the configuration port from the request registers.
  // ---------------------------------------------------------------------------
  assign port.addr = ifAddr_r;
  assign port.funcNum = ifFunc_r;
  assign port.writeData = ifWdata_r;
  assign port.byteEn = ifBen_r;
  assign port.writeReq = ifWrite_r;
  assign port.readReq = ifRead_r;
  assign port.debugAccess = ifDebug_r;

endmodule

//--- rtl/csmp_pkg.sv
package csmp_pkg;

  // ---------------------------------------------------------------------------
  // Port widths.
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int FUNC_W = 8;
  localparam int DATA_W = 32;
  localparam int BE_W = 4;

  // ---------------------------------------------------------------------------
  // Configuration space byte offsets; the port carries them as dword addresses.
  // ---------------------------------------------------------------------------
  localparam logic [11:0] BYTE_CMD_STATUS = 12'h004;
  localparam logic [11:0] BYTE_BASE_ZERO = 12'h010;
  localparam logic [11:0] BYTE_LINK_CTRL = 12'h080;
  localparam logic [11:0] BYTE_LB_CAP = 12'h330;
  localparam logic [11:0] BYTE_LB_CTRL = 12'h338;
  localparam logic [9:0] DW_CMD_STATUS = BYTE_CMD_STATUS[11:2];
  localparam logic [9:0] DW_BASE_ZERO = BYTE_BASE_ZERO[11:2];
  localparam logic [9:0] DW_LINK_CTRL = BYTE_LINK_CTRL[11:2];
  localparam logic [9:0] DW_LB_CAP = BYTE_LB_CAP[11:2];
  localparam logic [9:0] DW_LB_CTRL = BYTE_LB_CTRL[11:2];

  // ---------------------------------------------------------------------------
  // Stored register indices, read-only masks and reset values.
  // ---------------------------------------------------------------------------
  localparam int NUM_REGS = 5;
  localparam logic [2:0] IDX_CMD_STATUS = 3'h0;
  localparam logic [2:0] IDX_BASE_ZERO = 3'h1;
  localparam logic [2:0] IDX_LINK_CTRL = 3'h2;
  localparam logic [2:0] IDX_LB_CAP = 3'h3;
  localparam logic [2:0] IDX_LB_CTRL = 3'h4;
  localparam logic [2:0] IDX_NONE = 3'h7;
  localparam logic [31:0] RO_MASK_CMD_STATUS = 32'hffff_0000;
  localparam logic [31:0] RO_MASK_LB_CAP = 32'hffff_ffff;
  localparam logic [31:0] RO_MASK_NONE = 32'h0000_0000;
  localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
  // Capability header value is arbitrary.
  localparam logic [31:0] LB_CAP_INIT = 32'h0001_000b;
  localparam logic [FUNC_W-1:0] FUNC_IMPLEMENTED = 8'h00;
  localparam int LB_START_BIT = 0;
  localparam int LINK_RETRAIN_BIT = 5;
  localparam logic [2:0] WRITE_LAT = 3'h3;

  // ---------------------------------------------------------------------------
  // Canned loopback start and link retrain writes.
  // ---------------------------------------------------------------------------
  localparam logic [31:0] LB_START_DATA = 32'h0000_0001;
  localparam logic [3:0] LB_START_BE = 4'h1;
  localparam logic [31:0] RETRAIN_DATA = 32'h0000_0020;
  localparam logic [3:0] RETRAIN_BE = 4'h1;

  // ---------------------------------------------------------------------------
  // Requester APB register offsets and bits.
  // ---------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_FUNC = 8'h08;
  localparam logic [7:0] REG_WDATA = 8'h0c;
  localparam logic [7:0] REG_BEN = 8'h10;
  localparam logic [7:0] REG_STAT = 8'h14;
  localparam logic [7:0] REG_RDATA = 8'h18;
  localparam int CTRL_GO = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_DEBUG = 2;
  localparam int CTRL_LOOPBACK = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;

  typedef enum logic [1:0] {LB_NONE, LB_START, LB_RETRAIN} csmp_lb_e;

endpackage

//--- rtl/csmp_if.sv
`timescale 1ns/1ps
interface csmp_if;
  logic [csmp_pkg::ADDR_W-1:0] addr;
  logic [csmp_pkg::FUNC_W-1:0] funcNum;
  logic [csmp_pkg::DATA_W-1:0] writeData;
  logic [csmp_pkg::BE_W-1:0] byteEn;
  logic writeReq;
  logic readReq;
  logic debugAccess;
  logic [csmp_pkg::DATA_W-1:0] readData;
  logic done;

  modport dev (
    input addr,
    input funcNum,
    input writeData,
    input byteEn,
    input writeReq,
    input readReq,
    input debugAccess,
    output readData,
    output done
  );

  modport req (
    output addr,
    output funcNum,
    output writeData,
    output byteEn,
    output writeReq,
    output readReq,
    output debugAccess,
    input readData,
    input done
  );
endinterface

//--- rtl/csmp_device.sv
`timescale 1ns/1ps
module csmp_device (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rootPortMode,
  csmp_if.dev port,
  output logic loopbackActive,
  output logic linkRetrain
);

  // ---------------------------------------------------------------------------
  // State and storage.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, WRITING, RESPOND, WAIT_DROP} csmp_dev_e;

  csmp_dev_e state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic [31:0] rdData_r, rdData_nxt;
  logic retrain_r, retrain_nxt;
  logic [31:0] cfg_r [csmp_pkg::NUM_REGS];
  logic [31:0] cfg_nxt [csmp_pkg::NUM_REGS];
  logic [2:0] idx;
  logic [31:0] roMask;
  logic [31:0] oldWord;
  logic [31:0] mergedWord;
  logic override;

  // Decode the dword address of function zero into a storage index.
  always_comb
  begin
    idx = csmp_pkg::IDX_NONE;
    roMask = csmp_pkg::RO_MASK_NONE;
    if (port.funcNum == csmp_pkg::FUNC_IMPLEMENTED)
    begin
      unique case (port.addr)
        csmp_pkg::DW_CMD_STATUS:
        begin
          idx = csmp_pkg::IDX_CMD_STATUS;
          roMask = csmp_pkg::RO_MASK_CMD_STATUS;
        end
        csmp_pkg::DW_BASE_ZERO: idx = csmp_pkg::IDX_BASE_ZERO;
        csmp_pkg::DW_LINK_CTRL: idx = csmp_pkg::IDX_LINK_CTRL;
        csmp_pkg::DW_LB_CAP: // [R10]
        begin
          idx = csmp_pkg::IDX_LB_CAP;
          roMask = csmp_pkg::RO_MASK_LB_CAP;
        end
        csmp_pkg::DW_LB_CTRL: idx = csmp_pkg::IDX_LB_CTRL;
        default: idx = csmp_pkg::IDX_NONE;
      endcase
    end
  end

  // Read-only fields accept writes only under the root port override.
  assign override = rootPortMode & port.debugAccess; // [R8]
  assign oldWord = (idx == csmp_pkg::IDX_NONE) ? csmp_pkg::RESET_ZERO : cfg_r[idx];

  // Merge write data per byte lane under the byte enables.
  for (genvar b = 0; b < csmp_pkg::BE_W; b++)
  begin : gMerge
    for (genvar k = 0; k < 8; k++)
    begin : gBit
      assign mergedWord[8*b+k] = (port.byteEn[b] & (override | ~roMask[8*b+k])) ?
        port.writeData[8*b+k] : oldWord[8*b+k]; // [R8]
    end
  end

  // Access sequencer: one done pulse per request, then wait for release.
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    rdData_nxt = rdData_r;
    retrain_nxt = 1'b0;
    cfg_nxt = cfg_r;
    unique case (state_r)
      IDLE:
      begin
        if (port.writeReq)
        begin
          cnt_nxt = 3'h1;
          state_nxt = WRITING;
        end
        else if (port.readReq)
        begin
          rdData_nxt = oldWord; // [R3]
          state_nxt = RESPOND;
        end
      end
      WRITING:
      begin
        cnt_nxt = cnt_r + 3'h1;
        if (cnt_r == csmp_pkg::WRITE_LAT)
        begin
          state_nxt = RESPOND; // [R5]
          if (idx != csmp_pkg::IDX_NONE)
          begin
            cfg_nxt[idx] = mergedWord; // [R11]
          end
          if (idx == csmp_pkg::IDX_LINK_CTRL)
          begin
            retrain_nxt = mergedWord[csmp_pkg::LINK_RETRAIN_BIT];
            cfg_nxt[idx][csmp_pkg::LINK_RETRAIN_BIT] = 1'b0;
          end
        end
      end
      RESPOND: state_nxt = WAIT_DROP; // [R14]
      WAIT_DROP:
      begin
        if (!port.writeReq && !port.readReq)
        begin
          state_nxt = IDLE; // [R14]
        end
      end
    endcase
  end

  // Register the sequencer and the configuration storage.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= IDLE;
      cnt_r <= 3'h0;
      rdData_r <= csmp_pkg::RESET_ZERO;
      retrain_r <= 1'b0;
      for (int i = 0; i < csmp_pkg::NUM_REGS; i++)
      begin
        cfg_r[i] <= csmp_pkg::RESET_ZERO;
      end
      cfg_r[csmp_pkg::IDX_LB_CAP] <= csmp_pkg::LB_CAP_INIT;
    end
    else if (ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      rdData_r <= rdData_nxt;
      retrain_r <= retrain_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // Outputs; read data is the captured word, qualified by done.
  assign port.done = (state_r == RESPOND); // [R3]
  assign port.readData = rdData_r;
  assign loopbackActive = cfg_r[csmp_pkg::IDX_LB_CTRL][csmp_pkg::LB_START_BIT]; // [R11]
  assign linkRetrain = retrain_r;

endmodule

//--- testbench/csmp_chk.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Handshake checks on the configuration port between requester and device.
// ----------------------------------------------------------------------------
module csmp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [7:0] funcNum,
  input wire logic [31:0] writeData,
  input wire logic [3:0] byteEn,
  input wire logic writeReq,
  input wire logic readReq,
  input wire logic debugAccess,
  input wire logic [31:0] readData,
  input wire logic done
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // A write waits four quiet cycles before its strobe.
  sequence s_wr_wait;
    !done [*4] ##1 done;
  endsequence

  // A read is answered in the cycle after the device samples it.
  sequence s_rd_wait;
    !done ##1 done;
  endsequence

  // Both requests are low in the release cycle, and no strobe answers in the cycle after.
  sequence s_released;
    (!writeReq && !readReq) ##1 !done;
  endsequence

  a_done_pulse: assert property (done |=> !done)
    else $error("completion strobe longer than one cycle");
  a_wr_hold: assert property (writeReq && !done |=> writeReq && $stable(addr) &&
    $stable(funcNum) && $stable(writeData) && $stable(byteEn))
    else $error("write request changed before completion");
  a_rd_hold: assert property (readReq && !done |=> readReq && $stable(addr) &&
    $stable(funcNum))
    else $error("read request changed before completion");
  a_wr_drop: assert property (done && writeReq |=> !writeReq)
    else $error("write request not dropped after completion");
  a_rd_drop: assert property (done && readReq |=> !readReq)
    else $error("read request not dropped after completion");
  a_wr_latency: assert property ($rose(writeReq) |-> s_wr_wait)
    else $error("write completion at the wrong cycle");
  a_rd_latency: assert property ($rose(readReq) |-> s_rd_wait)
    else $error("read completion at the wrong cycle");
  a_one_request: assert property (done |=> s_released)
    else $error("new request without a release gap");
  a_rdata_hold: assert property ($changed(readData) |-> done)
    else $error("read data changed outside a completion");
  a_debug_write: assert property (debugAccess |-> writeReq)
    else $error("override raised without a write request");
endmodule

//--- testbench/config_space_mgmt_port_tb_top.sv
`timescale 1ns/1ps
module config_space_mgmt_port_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic rootPortMode = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic loopbackActive;
  logic linkRetrain;
  int badCount = 0;
  int samplesChecked = 0;
  int cycles = 0;
  int retrains = 0;
  int dones = 0;
  integer seed = 32'hdcf4;
  logic [31:0] sh [5];
  logic [11:0] off [5] = '{csmp_pkg::BYTE_CMD_STATUS, csmp_pkg::BYTE_BASE_ZERO,
    csmp_pkg::BYTE_LINK_CTRL, csmp_pkg::BYTE_LB_CAP, csmp_pkg::BYTE_LB_CTRL};
  logic [31:0] roM [5] = '{32'hffff_0000, 32'h0, 32'h0, 32'hffff_ffff, 32'h0};
  logic [9:0] wAddr [$];
  logic [31:0] wData [$];
  logic [31:0] q;
  logic e;

  csmp_if cfgIf ();

  always #12.5 clk = ~clk;

  csmp_requester csmp_requester_inst (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port(cfgIf.req));
  csmp_device csmp_device_inst (.clk(clk), .rst(rst), .ce(ce), .rootPortMode(rootPortMode),
    .port(cfgIf.dev), .loopbackActive(loopbackActive), .linkRetrain(linkRetrain));
  csmp_chk csmp_chk_inst (.clk(clk), .rst(rst), .addr(cfgIf.addr), .funcNum(cfgIf.funcNum),
    .writeData(cfgIf.writeData), .byteEn(cfgIf.byteEn), .writeReq(cfgIf.writeReq),
    .readReq(cfgIf.readReq), .debugAccess(cfgIf.debugAccess), .readData(cfgIf.readData),
    .done(cfgIf.done));

  // ----------------------------------------------------------------------------
  // Shared tasks.
  // ----------------------------------------------------------------------------
  // Prints the counts and the verdict, then stops.
  task conclude;
    $display("checks=%0d errors=%0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Compares one value and reports a mismatch.
  task check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp)
    begin
      badCount++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; the answer is taken at the edge where pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Loads the request registers, starts it, waits for done, clears it, reads data.
  task cfg(input logic [3:0] ctl, input logic [11:0] ba, input logic [7:0] fn,
    input logic [31:0] d, input logic [3:0] be);
    int n;
    apb(1'b1, csmp_pkg::REG_ADDR, {20'h0, ba});
    apb(1'b1, csmp_pkg::REG_FUNC, {24'h0, fn});
    apb(1'b1, csmp_pkg::REG_WDATA, d);
    apb(1'b1, csmp_pkg::REG_BEN, {28'h0, be});
    apb(1'b1, csmp_pkg::REG_CTRL, {28'h0, ctl});
    n = 0;
    q = 32'h0;
    while (q[1] !== 1'b1 && n < 60)
    begin
      apb(1'b0, csmp_pkg::REG_STAT, 32'h0);
      n++;
    end
    check({30'h0, q[1:0]}, 32'h2);
    apb(1'b1, csmp_pkg::REG_STAT, 32'h2);
    apb(1'b0, csmp_pkg::REG_RDATA, 32'h0);
  endtask

  // Expected register value after a masked write with protected bits.
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] be,
    logic [31:0] ro);
    merge = o;
    for (int b = 0; b < 4; b++)
      if (be[b])
        merge[8*b+:8] = (n[8*b+:8] & ~ro[8*b+:8]) | (o[8*b+:8] & ro[8*b+:8]);
  endfunction

  // ----------------------------------------------------------------------------
  // Port monitor and run limit.
  // ----------------------------------------------------------------------------
  // Records completed writes and strobes where the values have settled.
  always @(negedge clk)
  begin
    cycles++;
    if (linkRetrain === 1'b1)
      retrains++;
    if (cfgIf.done === 1'b1)
    begin
      dones++;
      if (cfgIf.writeReq === 1'b1)
      begin
        wAddr.push_back(cfgIf.addr);
        wData.push_back(cfgIf.writeData);
      end
    end
    if (cycles == 20000)
    begin
      badCount++;
      conclude;
    end
  end

  // ----------------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------------
  initial
  begin
    int k;
    int n0;
    logic [31:0] d;
    logic [3:0] be;
    logic dbg;
    logic rpm;
    sh = '{32'h0, 32'h0, 32'h0, csmp_pkg::LB_CAP_INIT, 32'h0};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, csmp_pkg::REG_STAT, 32'h0);
    check(q, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      cfg(4'h1, off[i], 8'h00, 32'h0, 4'h0);
      check(q, sh[i]);
    end
    // Random masked writes, some with the read-only override, each read back.
    for (int i = 0; i < 24; i++)
    begin
      k = ($random(seed) & 32'h7fff_ffff) % 5;
      d = $random(seed);
      be = 4'($random(seed));
      rpm = 1'($random(seed));
      dbg = 1'($random(seed)) && (k != 3);
      rootPortMode <= rpm;
      cfg({1'b0, dbg, 2'b11}, off[k], 8'h00, d, be);
      sh[k] = merge(sh[k], d, be, (dbg && rpm) ? 32'h0 : roM[k]);
      sh[2][5] = 1'b0;
      check({22'h0, wAddr[$]}, {22'h0, off[k][11:2]});
      check(wData[$], d);
      cfg(4'h1, off[k], 8'h00, 32'h0, 4'h0);
      check(q, sh[k]);
      check({31'h0, loopbackActive}, {31'h0, sh[4][0]});
    end
    // Another function neither stores nor disturbs function zero.
    cfg(4'h3, off[1], 8'h01, 32'hffff_ffff, 4'hf);
    cfg(4'h1, off[1], 8'h01, 32'h0, 4'h0);
    check(q, 32'h0);
    cfg(4'h1, off[1], 8'h00, 32'h0, 4'h0);
    check(q, sh[1]);
    apb(1'b0, 8'h1c, 32'h0);
    check({31'h0, e}, 32'h1);
    apb(1'b0, csmp_pkg::REG_RDATA, 32'h0);
    check({31'h0, e}, 32'h0);
    // A second start while busy is refused: one strobe only.
    n0 = dones;
    apb(1'b1, csmp_pkg::REG_CTRL, 32'h3);
    apb(1'b1, csmp_pkg::REG_CTRL, 32'h3);
    cfg(4'h0, off[1], 8'h00, 32'h0, 4'h0);
    repeat (20) @(posedge clk);
    check(32'(dones - n0), 32'h1);
    // Loopback start followed by the link retrain write.
    n0 = retrains;
    cfg(4'h8, off[1], 8'h00, 32'h0, 4'h0);
    check({22'h0, wAddr[$-1]}, 32'h0ce);
    check(wData[$-1], 32'h1);
    check({22'h0, wAddr[$]}, 32'h020);
    check(wData[$], 32'h20);
    check(32'(retrains - n0), 32'h1);
    check({31'h0, loopbackActive}, 32'h1);
    sh[4] = merge(sh[4], 32'h1, 4'h1, 32'h0);
    sh[2] = merge(sh[2], 32'h20, 4'h1, 32'h0) & ~32'h20;
    cfg(4'h1, off[2], 8'h00, 32'h0, 4'h0);
    check(q, sh[2]);
    // A low clock enable stalls the register bus until it returns.
    ce <= 1'b0;
    fork
      apb(1'b1, csmp_pkg::REG_WDATA, 32'h5a5a_00c3);
      begin
        repeat (6) @(posedge clk);
        ce <= 1'b1;
      end
    join
    apb(1'b0, csmp_pkg::REG_WDATA, 32'h0);
    check(q, 32'h5a5a_00c3);
    // A reset in mid-run clears the loopback control.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    check({31'h0, loopbackActive}, 32'h0);
    cfg(4'h1, off[4], 8'h00, 32'h0, 4'h0);
    check(q, 32'h0);
    conclude;
  end
endmodule
